// ==== include/pct_defines.vh ====
// register offsets, field positions, reset values and timing counts
`ifndef PCT_DEFINES_VH
`define PCT_DEFINES_VH

`define PCT_OFF_HEADER      8'h00
`define PCT_OFF_LENGTH      8'h01
`define PCT_OFF_PREC_STBY   8'h02
`define PCT_OFF_IDLE_EN     8'h03
`define PCT_OFF_IDLE_A_VAL  8'h04
`define PCT_OFF_STBY_Z_VAL  8'h08
`define PCT_OFF_IDLE_B_VAL  8'h0c
`define PCT_OFF_IDLE_C_VAL  8'h10
`define PCT_OFF_STBY_Y_VAL  8'h14
`define PCT_OFF_CCF         8'h27
`define PCT_OFF_STATUS      8'h28
`define PCT_OFF_IRQ_STAT    8'h2c
`define PCT_OFF_IRQ_MASK    8'h30
`define PCT_OFF_UNLOADS     8'h34

`define PCT_RST_HEADER      8'h9a
`define PCT_RST_LENGTH      8'h26
`define PCT_RST_PREC_STBY   8'h00
`define PCT_RST_IDLE_EN     8'h06
`define PCT_RST_IDLE_A_VAL  32'h00000014
`define PCT_RST_STBY_Z_VAL  32'h00000000
`define PCT_RST_IDLE_B_VAL  32'h00001770
`define PCT_RST_IDLE_C_VAL  32'h00000000
`define PCT_RST_STBY_Y_VAL  32'h00000000
`define PCT_RST_CCF         8'h58

// field positions
`define PCT_PREC_HI         7
`define PCT_PREC_LO         6
`define PCT_STBY_Y_EN_BIT   0
`define PCT_STBY_Z_EN_BIT   0
`define PCT_IDLE_A_EN_BIT   1
`define PCT_IDLE_B_EN_BIT   2
`define PCT_IDLE_C_EN_BIT   3
`define PCT_AFTER_IDLE_STATUS_SELECT_HI     7
`define PCT_AFTER_IDLE_STATUS_SELECT_LO     6
`define PCT_CCF_STBY_HI     5
`define PCT_CCF_STBY_LO     4
`define PCT_CCF_STOP_HI     3
`define PCT_CCF_STOP_LO     2
`define PCT_CCF_DISABLE     2'h1
`define PCT_CCF_ENABLE      2'h2
`define PCT_IRQ_ENTER_BIT   0
`define PCT_IRQ_CHECK_BIT   1
`define PCT_IRQ_DENY_BIT    2

// timing
`define PCT_CLK_PERIOD_NS   8
`define PCT_UNIT_MS         100
`define PCT_UNIT_CYCLES     ((`PCT_UNIT_MS * 1000000) / `PCT_CLK_PERIOD_NS)
`define PCT_MIN_IDLE_A_MS   1000
`define PCT_MIN_OTHER_MIN   2
`define PCT_MIN_IDLE_A_UNITS (`PCT_MIN_IDLE_A_MS / `PCT_UNIT_MS)
`define PCT_MIN_OTHER_UNITS ((`PCT_MIN_OTHER_MIN * 60000) / `PCT_UNIT_MS)
`define PCT_WINDOW_HOURS    24
`define PCT_WINDOW_UNITS    ((`PCT_WINDOW_HOURS * 3600000) / `PCT_UNIT_MS)
`define PCT_MAX_UNLOADS     60

`endif

// ==== verilog/pct_stamp_mem.v ====
// small memory of head unload time stamps with registered read data
`timescale 1ns/1ps

module pct_stamp_mem #(
   parameter WIDTH = 32,
   parameter DEPTH = 60,
   parameter AW    = 6
) (
   input  wire             clk_i,
   input  wire             arst_n_i,
   input  wire             we_i,
   input  wire [AW-1:0]    waddr_i,
   input  wire [WIDTH-1:0] wdata_i,
   input  wire [AW-1:0]    raddr_i,
   output reg  [WIDTH-1:0] rdata_o
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];

   always @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_o <= {WIDTH{1'b0}};
      end else begin
         rdata_o <= mem[raddr_i];
      end
   end

endmodule // pct_stamp_mem

// ==== verilog/pct_top.v ====
// power condition timers, head unload limiter and parameter page registers
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "pct_defines.vh"

// Operation
// - each of the five timers runs only while its enable bit is one.
// - each timer value is an initial countdown in 100 ms inactivity units.
// - a first idle value under one second is used as one second.
// - other idle and both standby values under two minutes become two minutes.
// - at most sixty timer-caused head unloads occur in any rolling 24 hours.
// - the idle exit field gives check status on 10b, none on 01b.
// - a two-bit precedence field sets how background work meets low power.
// - standby and stopped exit fields work like the idle one.
// - precedence 00h behaves as 01b, background first.
// - under 00b and 01b, background work finishes, then the highest expired timer is entered.
module pct_top #(
   parameter TICK_CYCLES = `PCT_UNIT_CYCLES,
   parameter WINDOW_UNITS = `PCT_WINDOW_UNITS
) (
   input  wire        MCLK_I,
   input  wire        ARST_N_I,
   input  wire [7:0]  ADDR_I,
   input  wire [31:0] WDATA_I,
   input  wire        WR_I,
   input  wire        RD_I,
   output reg  [31:0] RDATA_O,
   input  wire        HOST_ACTIVITY_I,
   input  wire        BG_BUSY_I,
   input  wire        STOPPED_I,
   output wire [2:0]  POWER_STATE_O,
   output wire        HEADS_UNLOADED_O,
   output reg         CHECK_COND_O,
   output wire        IRQ_O
);

   localparam [2:0] ST_ACTIVE = 3'h0;
   localparam [2:0] ST_IDLE_A = 3'h1;
   localparam [2:0] ST_IDLE_B = 3'h2;
   localparam [2:0] ST_IDLE_C = 3'h3;
   localparam [2:0] ST_STBY_Y = 3'h4;
   localparam [2:0] ST_STBY_Z = 3'h5;
   localparam [23:0] TICK_LAST = TICK_CYCLES[23:0] - 24'h000001;
   localparam [31:0] WINDOW = WINDOW_UNITS;
   localparam [5:0] MAX_UNL = `PCT_MAX_UNLOADS;
   localparam [5:0] LAST_SLOT = MAX_UNL - 6'h01;
   localparam [31:0] MIN_A = `PCT_MIN_IDLE_A_UNITS;
   localparam [31:0] MIN_O = `PCT_MIN_OTHER_UNITS;

   ////////////////////////////////////////////////////////////////////////
   // page registers
   reg  [7:0]  prec_stby_reg;
   reg  [7:0]  idle_en_reg;
   reg  [7:0]  ccf_reg;
   reg  [31:0] tval_reg [0:4];
   reg  [2:0]  irq_stat_reg;
   reg  [2:0]  irq_mask_reg;
   reg  [2:0]  state_reg;
   reg  [2:0]  state_next;
   reg  [23:0] tick_cnt_reg;
   reg  [31:0] now_reg;
   reg         init_reg;
   reg  [5:0]  unl_cnt_reg;
   reg  [5:0]  wr_ptr_reg;
   reg         mem_fresh_reg;
   reg         stopped_d_reg;
   reg  [2:0]  evt;
   reg         log_unload;
   reg         chk;
   reg  [2:0]  target;
   reg  [31:0] rd_next;
   wire [31:0] stamp;
   wire [4:0]  tmr_en;
   wire [4:0]  expired;
   wire        tick;
   wire        bg_first;
   wire        unload_ok;
   wire        wr_hit_ccf;
   integer     i;

   wire [1:0] background_priority_select =
      prec_stby_reg[`PCT_PREC_HI:`PCT_PREC_LO];
   wire [1:0] after_idle_status_select =
      ccf_reg[`PCT_AFTER_IDLE_STATUS_SELECT_HI:`PCT_AFTER_IDLE_STATUS_SELECT_LO];
   wire [1:0] after_standby_status_select =
      ccf_reg[`PCT_CCF_STBY_HI:`PCT_CCF_STBY_LO];
   wire [1:0] after_halt_status_select =
      ccf_reg[`PCT_CCF_STOP_HI:`PCT_CCF_STOP_LO];

   // timer index: 0 idle a, 1 idle b, 2 idle c, 3 standby y, 4 standby z
   assign tmr_en = {idle_en_reg[`PCT_STBY_Z_EN_BIT],
                    prec_stby_reg[`PCT_STBY_Y_EN_BIT],
                    idle_en_reg[`PCT_IDLE_C_EN_BIT],
                    idle_en_reg[`PCT_IDLE_B_EN_BIT],
                    idle_en_reg[`PCT_IDLE_A_EN_BIT]};

   assign wr_hit_ccf = WR_I && (ADDR_I == `PCT_OFF_CCF);

   always @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         prec_stby_reg <= `PCT_RST_PREC_STBY;
         idle_en_reg   <= `PCT_RST_IDLE_EN;
         ccf_reg       <= `PCT_RST_CCF;
         tval_reg[0]   <= `PCT_RST_IDLE_A_VAL;
         tval_reg[1]   <= `PCT_RST_IDLE_B_VAL;
         tval_reg[2]   <= `PCT_RST_IDLE_C_VAL;
         tval_reg[3]   <= `PCT_RST_STBY_Y_VAL;
         tval_reg[4]   <= `PCT_RST_STBY_Z_VAL;
         irq_mask_reg  <= 3'h0;
      end else if (WR_I) begin
         case (ADDR_I)
            `PCT_OFF_PREC_STBY:  prec_stby_reg <= WDATA_I[7:0] & 8'hc1;
            `PCT_OFF_IDLE_EN:    idle_en_reg <= WDATA_I[7:0] & 8'h0f;
            `PCT_OFF_IDLE_A_VAL: tval_reg[0] <= WDATA_I;
            `PCT_OFF_IDLE_B_VAL: tval_reg[1] <= WDATA_I;
            `PCT_OFF_IDLE_C_VAL: tval_reg[2] <= WDATA_I;
            `PCT_OFF_STBY_Y_VAL: tval_reg[3] <= WDATA_I;
            `PCT_OFF_STBY_Z_VAL: tval_reg[4] <= WDATA_I;
            `PCT_OFF_IRQ_MASK:   irq_mask_reg <= WDATA_I[2:0];
            default: ;
         endcase
         // unusable codes 00b and 11b leave the field as it was
         if (wr_hit_ccf) begin
            if (WDATA_I[7] != WDATA_I[6]) begin
               ccf_reg[7:6] <= WDATA_I[7:6];
            end
            if (WDATA_I[5] != WDATA_I[4]) begin
               ccf_reg[5:4] <= WDATA_I[5:4];
            end
            if (WDATA_I[3] != WDATA_I[2]) begin
               ccf_reg[3:2] <= WDATA_I[3:2];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // 100 ms time base and free running unit clock for unload stamps
   assign tick = (tick_cnt_reg == TICK_LAST);

   always @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         tick_cnt_reg <= 24'h000000;
         now_reg      <= 32'h00000000;
         init_reg     <= 1'b1;
      end else begin
         init_reg <= 1'b0;
         if (tick) begin
            tick_cnt_reg <= 24'h000000;
            now_reg      <= now_reg + 32'h00000001;
         end else begin
            tick_cnt_reg <= tick_cnt_reg + 24'h000001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // inactivity timers
   genvar g;
   generate
      for (g = 0; g < 5; g = g + 1) begin : tmr
         reg  [31:0] cnt_reg;
         wire [31:0] floor_val = (g == 0) ? MIN_A : MIN_O;
         // short values are accepted but replaced by the floor
         wire [31:0] eff = (tval_reg[g] < floor_val) ? floor_val
                                                      : tval_reg[g];
         always @(posedge MCLK_I or negedge ARST_N_I) begin
            if (!ARST_N_I) begin
               cnt_reg <= 32'h00000000;
            end else if (init_reg || HOST_ACTIVITY_I || !tmr_en[g]) begin
               cnt_reg <= eff;
            end else if (tick && (cnt_reg != 32'h00000000)) begin
               cnt_reg <= cnt_reg - 32'h00000001;
            end
         end
         assign expired[g] = tmr_en[g] && !init_reg &&
                             (cnt_reg == 32'h00000000);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // rolling unload window: a new unload needs the sixtieth-last one to be
   // a full window old; the slot at the write pointer is that oldest stamp
   pct_stamp_mem #(
      .WIDTH (32),
      .DEPTH (`PCT_MAX_UNLOADS),
      .AW    (6)
   ) u_stamps (
      .clk_i    (MCLK_I),
      .arst_n_i (ARST_N_I),
      .we_i     (log_unload),
      .waddr_i  (wr_ptr_reg),
      .wdata_i  (now_reg),
      .raddr_i  (wr_ptr_reg),
      .rdata_o  (stamp)
   );

   assign unload_ok = (unl_cnt_reg != MAX_UNL) ||
                      (mem_fresh_reg &&
                       ((now_reg - stamp) >= WINDOW));

   always @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         unl_cnt_reg   <= 6'h00;
         wr_ptr_reg    <= 6'h00;
         mem_fresh_reg <= 1'b0;
      end else begin
         // read data lag one cycle behind a pointer move
         mem_fresh_reg <= !log_unload;
         if (log_unload) begin
            wr_ptr_reg <= (wr_ptr_reg == LAST_SLOT) ? 6'h00
                                                    : wr_ptr_reg + 6'h01;
            if (unl_cnt_reg != MAX_UNL) begin
               unl_cnt_reg <= unl_cnt_reg + 6'h01;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // power condition sequencing
   // codes 00b and 01b give background work the upper hand
   assign bg_first = !background_priority_select[1];

   always @* begin
      target = ST_ACTIVE;
      for (i = 0; i < 5; i = i + 1) begin
         if (expired[i]) begin
            target = i[2:0] + 3'h1;
         end
      end
   end

   always @* begin
      state_next = state_reg;
      log_unload = 1'b0;
      chk        = 1'b0;
      evt        = 3'h0;
      if (HOST_ACTIVITY_I) begin
         if (state_reg != ST_ACTIVE) begin
            state_next = ST_ACTIVE;
            if (state_reg >= ST_STBY_Y) begin
               chk = (after_standby_status_select == `PCT_CCF_ENABLE);
            end else begin
               chk = (after_idle_status_select == `PCT_CCF_ENABLE);
            end
         end
      end else if (bg_first && BG_BUSY_I) begin
         state_next = ST_ACTIVE;
      end else if (target > state_reg) begin
         if ((state_reg < ST_IDLE_B) && (target >= ST_IDLE_B)) begin
            if (unload_ok) begin
               state_next = target;
               log_unload = 1'b1;
               evt[`PCT_IRQ_ENTER_BIT] = 1'b1;
            end else begin
               evt[`PCT_IRQ_DENY_BIT] = 1'b1;
               if (expired[0] && (state_reg == ST_ACTIVE)) begin
                  state_next = ST_IDLE_A;
                  evt[`PCT_IRQ_ENTER_BIT] = 1'b1;
               end
            end
         end else begin
            state_next = target;
            evt[`PCT_IRQ_ENTER_BIT] = 1'b1;
         end
      end
      if (stopped_d_reg && !STOPPED_I &&
          (after_halt_status_select == `PCT_CCF_ENABLE)) begin
         chk = 1'b1;
      end
      evt[`PCT_IRQ_CHECK_BIT] = chk;
   end

   always @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         state_reg     <= ST_ACTIVE;
         stopped_d_reg <= 1'b0;
         CHECK_COND_O  <= 1'b0;
         irq_stat_reg  <= 3'h0;
      end else begin
         state_reg     <= state_next;
         stopped_d_reg <= STOPPED_I;
         CHECK_COND_O  <= chk;
         // a new event wins over a write-one clear in the same cycle
         if (WR_I && (ADDR_I == `PCT_OFF_IRQ_STAT)) begin
            irq_stat_reg <= (irq_stat_reg & ~WDATA_I[2:0]) | evt;
         end else begin
            irq_stat_reg <= irq_stat_reg | evt;
         end
      end
   end

   assign POWER_STATE_O    = state_reg;
   assign HEADS_UNLOADED_O = (state_reg >= ST_IDLE_B);
   assign IRQ_O            = |(irq_stat_reg & irq_mask_reg);

   ////////////////////////////////////////////////////////////////////////
   // read port, data one cycle after the strobe
   always @* begin
      rd_next = 32'h00000000;
      case (ADDR_I)
         `PCT_OFF_HEADER:     rd_next = {24'h000000, `PCT_RST_HEADER};
         `PCT_OFF_LENGTH:     rd_next = {24'h000000, `PCT_RST_LENGTH};
         `PCT_OFF_PREC_STBY:  rd_next = {24'h000000, prec_stby_reg};
         `PCT_OFF_IDLE_EN:    rd_next = {24'h000000, idle_en_reg};
         `PCT_OFF_IDLE_A_VAL: rd_next = tval_reg[0];
         `PCT_OFF_IDLE_B_VAL: rd_next = tval_reg[1];
         `PCT_OFF_IDLE_C_VAL: rd_next = tval_reg[2];
         `PCT_OFF_STBY_Y_VAL: rd_next = tval_reg[3];
         `PCT_OFF_STBY_Z_VAL: rd_next = tval_reg[4];
         `PCT_OFF_CCF:        rd_next = {24'h000000, ccf_reg};
         `PCT_OFF_STATUS:     rd_next = {19'h00000, expired,
                                         4'h0, HEADS_UNLOADED_O, state_reg};
         `PCT_OFF_IRQ_STAT:   rd_next = {29'h00000000, irq_stat_reg};
         `PCT_OFF_IRQ_MASK:   rd_next = {29'h00000000, irq_mask_reg};
         `PCT_OFF_UNLOADS:    rd_next = {26'h0000000, unl_cnt_reg};
         default:             rd_next = 32'h00000000;
      endcase
   end

   always @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         RDATA_O <= 32'h00000000;
      end else if (RD_I) begin
         RDATA_O <= rd_next;
      end else begin
         RDATA_O <= 32'h00000000;
      end
   end

endmodule // pct_top

// ==== tb/pct_top_chk.sv ====
// port assertions for the power condition timer block
`timescale 1ns/1ps

module pct_top_chk #(
   parameter TICK_CYCLES = 4
) (
   input wire        MCLK_I,
   input wire        ARST_N_I,
   input wire [7:0]  ADDR_I,
   input wire [31:0] WDATA_I,
   input wire        WR_I,
   input wire        RD_I,
   input wire [31:0] RDATA_O,
   input wire        HOST_ACTIVITY_I,
   input wire        BG_BUSY_I,
   input wire        STOPPED_I,
   input wire [2:0]  POWER_STATE_O,
   input wire        HEADS_UNLOADED_O,
   input wire        CHECK_COND_O,
   input wire        IRQ_O
);
   // shadows of the enables and precedence, plus cycles since host activity
   reg [31:0] quiet_reg;
   reg [1:0]  prec_reg;
   reg [4:0]  en_reg;

   always @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         quiet_reg <= 32'h0;
         prec_reg <= 2'h0;
         en_reg <= 5'h06;
      end else begin
         quiet_reg <= HOST_ACTIVITY_I ? 32'h0 : quiet_reg + 32'h1;
         if (WR_I && ADDR_I == 8'h03)
            en_reg[3:0] <= WDATA_I[3:0];
         if (WR_I && ADDR_I == 8'h02) begin
            en_reg[4] <= WDATA_I[0];
            prec_reg <= WDATA_I[7:6];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!ARST_N_I);

   a_host_wakes: assert property (HOST_ACTIVITY_I |=> POWER_STATE_O == 3'h0)
      else $error("state not active after host activity");
   a_none_enabled: assert property ((en_reg == 5'h0 && POWER_STATE_O == 3'h0)
      |=> POWER_STATE_O == 3'h0) else $error("low power with no timer enabled");
   // a lower bound only: tick phase makes the exact entry cycle vary
   a_idle_a_floor: assert property ((POWER_STATE_O == 3'h1
      && $past(POWER_STATE_O) == 3'h0) |-> quiet_reg >= 9 * TICK_CYCLES)
      else $error("first idle entered before one second");
   a_deep_floor: assert property ((POWER_STATE_O >= 3'h2
      && $past(POWER_STATE_O) < 3'h2) |-> quiet_reg >= 1199 * TICK_CYCLES)
      else $error("deeper state entered before two minutes");
   a_bg_first: assert property ((!prec_reg[1] && BG_BUSY_I)
      |=> POWER_STATE_O == 3'h0) else $error("background did not hold active");
   a_check_single: assert property (CHECK_COND_O |=> !CHECK_COND_O)
      else $error("check pulse longer than one cycle");
   a_check_cause: assert property (CHECK_COND_O |->
      ($past(HOST_ACTIVITY_I) && $past(POWER_STATE_O) != 3'h0)
      || ($past(STOPPED_I, 2) && !$past(STOPPED_I)))
      else $error("check pulse without an exit");
   a_heads_level: assert property (HEADS_UNLOADED_O == (POWER_STATE_O >= 3'h2))
      else $error("heads flag disagrees with state");
   a_read_quiet: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
      else $error("read data outside its cycle");
   a_length_ro: assert property ((RD_I && ADDR_I == 8'h01)
      |=> RDATA_O == 32'h26) else $error("page length wrong");

   cover property (CHECK_COND_O);
   cover property (POWER_STATE_O == 3'h2);
   cover property (IRQ_O);
endmodule // pct_top_chk

bind pct_top pct_top_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I), .ADDR_I(ADDR_I),
   .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
   .HOST_ACTIVITY_I(HOST_ACTIVITY_I), .BG_BUSY_I(BG_BUSY_I),
   .STOPPED_I(STOPPED_I), .POWER_STATE_O(POWER_STATE_O),
   .HEADS_UNLOADED_O(HEADS_UNLOADED_O), .CHECK_COND_O(CHECK_COND_O),
   .IRQ_O(IRQ_O));

// ==== tb/pct_host_model.sv ====
// host side model: activity, background work and stopped condition
`timescale 1ns/1ps

module pct_host_model (
   input  wire clk_i,
   output reg  host_activity_o,
   output reg  bg_busy_o,
   output reg  stopped_o
);
   initial begin
      host_activity_o = 1'b0;
      bg_busy_o = 1'b0;
      stopped_o = 1'b0;
   end

   // one cycle of activity, the shortest a host command can look
   task poke;
      @(posedge clk_i);
      host_activity_o <= 1'b1;
      @(posedge clk_i);
      host_activity_o <= 1'b0;
   endtask

   task set_bg(input logic b);
      @(posedge clk_i);
      bg_busy_o <= b;
   endtask

   task set_stop(input logic b);
      @(posedge clk_i);
      stopped_o <= b;
   endtask
endmodule // pct_host_model

// ==== tb/test_power_condition_timer_control.sv ====
// self-checking bench for the power condition timer block
`timescale 1ns/1ps

module test_power_condition_timer_control;
   // short tick keeps the two minute floor near 4800 cycles
   localparam TICK = 4;
   logic        mclk = 1'b0;
   logic        arst_n;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        act, bg, stp, heads, chk_o, irq;
   logic [2:0]  state;
   int          error_cnt = 0;
   int          num_checks = 0;
   logic [7:0]  offs [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
                               8'h08, 8'h0c, 8'h10, 8'h14, 8'h27};
   logic [31:0] rst_v [10] = '{32'h9a, 32'h26, 32'h0, 32'h06, 32'h14,
                               32'h0, 32'h1770, 32'h0, 32'h0, 32'h58};

   always #4 mclk = ~mclk;

   pct_top #(.TICK_CYCLES(TICK), .WINDOW_UNITS(50)) u_dut (
      .MCLK_I(mclk), .ARST_N_I(arst_n), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .HOST_ACTIVITY_I(act),
      .BG_BUSY_I(bg), .STOPPED_I(stp), .POWER_STATE_O(state),
      .HEADS_UNLOADED_O(heads), .CHECK_COND_O(chk_o), .IRQ_O(irq));

   pct_host_model u_host (.clk_i(mclk), .host_activity_o(act),
      .bg_busy_o(bg), .stopped_o(stp));

   ////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task chk_rng(input int n, input int lo, input int hi);
      num_checks++;
      if (n < lo || n > hi) begin
         error_cnt++;
         $display("unexpected at %0t: cycles %h, window %h..%h",
                  $time, n, lo, hi);
      end
   endtask

   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask

   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask

   task wait_state(input logic [2:0] s, input int lo, input int hi);
      int n;
      n = 0;
      #1;
      while (state !== s && n <= hi) begin
         @(posedge mclk);
         #1 n++;
      end
      chk_rng(n, lo, hi);
   endtask

   task wrap_up;
      $display("checks %0d, errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      // two floor-length waits of about 4800 cycles each dominate the run
      #150000;
      error_cnt++;
      wrap_up;
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      arst_n = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      repeat (5) @(posedge mclk);
      arst_n <= 1'b1;
      for (int i = 0; i < 10; i++)
         rd_chk(offs[i], rst_v[i]);
      wr_reg(8'h00, 32'h0);
      rd_chk(8'h00, 32'h9a);
      wr_reg(8'h18, 32'h55);
      rd_chk(8'h18, 32'h0);
      wr_reg(8'h02, 32'hff);
      rd_chk(8'h02, 32'hc1);
      wr_reg(8'h02, 32'h0);
      wr_reg(8'h03, 32'hff);
      rd_chk(8'h03, 32'h0f);
      wr_reg(8'h03, 32'h02);
      u_host.poke();
      wait_state(3'h1, 74, 86);
      wr_reg(8'h04, 32'h5);
      u_host.poke();
      wait_state(3'h1, 34, 46);
      wr_reg(8'h03, 32'h0);
      u_host.poke();
      repeat (100) @(posedge mclk);
      #1 chk({29'h0, state}, 32'h0);
      // background holds active past expiry, then the expired timer wins
      wr_reg(8'h03, 32'h02);
      u_host.set_bg(1'b1);
      u_host.poke();
      repeat (60) @(posedge mclk);
      #1 chk({29'h0, state}, 32'h0);
      u_host.set_bg(1'b0);
      wait_state(3'h1, 0, 3);
      wr_reg(8'h02, 32'h80);
      u_host.set_bg(1'b1);
      u_host.poke();
      wait_state(3'h1, 34, 46);
      u_host.set_bg(1'b0);
      wr_reg(8'h02, 32'h0);
      wr_reg(8'h27, 32'h0);
      rd_chk(8'h27, 32'h58);
      wr_reg(8'h27, 32'hff);
      rd_chk(8'h27, 32'h58);
      wr_reg(8'h27, 32'h98);
      rd_chk(8'h27, 32'h98);
      wr_reg(8'h30, 32'h2);
      wr_reg(8'h2c, 32'h7);
      wr_reg(8'h0c, 32'h5);
      wr_reg(8'h03, 32'h04);
      u_host.poke();
      wait_state(3'h2, 4790, 4810);
      chk({31'h0, heads}, 32'h1);
      rd_chk(8'h34, 32'h1);
      u_host.poke();
      #1 chk({31'h0, chk_o}, 32'h1);
      @(posedge mclk);
      #1 chk({31'h0, chk_o}, 32'h0);
      chk({31'h0, irq}, 32'h1);
      rd_chk(8'h2c, 32'h3);
      wr_reg(8'h2c, 32'h2);
      #1 chk({31'h0, irq}, 32'h0);
      rd_chk(8'h2c, 32'h1);
      u_host.set_stop(1'b1);
      u_host.set_stop(1'b0);
      @(posedge mclk);
      #1 chk({31'h0, chk_o}, 32'h1);
      wr_reg(8'h27, 32'h94);
      u_host.set_stop(1'b1);
      u_host.set_stop(1'b0);
      @(posedge mclk);
      #1 chk({31'h0, chk_o}, 32'h0);
      // precedence 01b holds active, then a standby entry and its exit pulse
      wr_reg(8'h27, 32'ha4);
      wr_reg(8'h03, 32'h02);
      wr_reg(8'h02, 32'h40);
      u_host.set_bg(1'b1);
      u_host.poke();
      repeat (60) @(posedge mclk);
      #1 chk({29'h0, state}, 32'h0);
      u_host.set_bg(1'b0);
      wait_state(3'h1, 0, 3);
      wr_reg(8'h03, 32'h00);
      wr_reg(8'h02, 32'h01);
      u_host.poke();
      wait_state(3'h4, 4790, 4810);
      rd_chk(8'h34, 32'h2);
      u_host.poke();
      #1 chk({31'h0, chk_o}, 32'h1);
      wrap_up;
   end
endmodule // test_power_condition_timer_control
